// *** ccv_charger_ctrl.sv ***
// Charge current and voltage control with its register pair and states.
`timescale 1ns/10ps
module ccv_charger_ctrl #(
  parameter int DEGLITCH_CYCLES = ccv_pkg::DEGLITCH_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire ccv_pkg::ccv_req_t  req_i,
  input  wire ccv_pkg::ccv_meas_t meas_i,
  input  wire logic [3:0]         input_current_limit_sel_i,
  input  wire logic               charge_en_i,
  input  wire logic               fc_timeout_i,
  input  wire logic               wdog_expired_i,
  input  wire logic               otp_load_i,
  input  wire logic [1:0]         otp_sysmin_i,
  output logic [7:0]              reg_rdata_o,
  output logic [10:0]             charge_current_ma_o,
  output logic [12:0]             battery_regulation_voltage_o,
  output logic                    charger_low_power_mode_o,
  output ccv_pkg::ccv_state_t     charge_state_o
);

  localparam logic [19:0] DEG_LAST = 20'(DEGLITCH_CYCLES - 1);

  ccv_pkg::ccv_regs_t st_reg;
  ccv_pkg::ccv_regs_t st_next;

  logic [4:0]  fast_charge_current_code;
  logic [5:0]  charge_voltage_code;
  logic [1:0]  system_min_voltage_sel;
  logic [10:0] lim_ma;
  logic [10:0] base_ma;
  logic [10:0] cap_ma;
  logic [12:0] loop_mv;
  logic        low_vsys;
  logic        below_eoc;

  function automatic logic [12:0] cv_mv(input logic [5:0] code);
    logic [5:0] c;
    c = code;
    if (c < ccv_pkg::CV_FLAT_CODE) begin
      c = ccv_pkg::CV_FLAT_CODE;
    end
    if (c > ccv_pkg::CV_CEIL_CODE) begin
      c = ccv_pkg::CV_CEIL_CODE;
    end
    cv_mv = 13'(ccv_pkg::CV_BASE_MV
          + ccv_pkg::CV_STEP_MV * 13'(c - ccv_pkg::CV_FLAT_CODE));
  endfunction : cv_mv

  assign fast_charge_current_code = st_reg.cur_reg[ccv_pkg::CC_LSB +: 5];
  assign charge_voltage_code = st_reg.vreg_reg[ccv_pkg::CV_LSB +: 6];
  assign system_min_voltage_sel = st_reg.vreg_reg[ccv_pkg::SYSMIN_LSB +: 2];
  assign lim_ma = ccv_pkg::LIM_MA[input_current_limit_sel_i];
  assign below_eoc = meas_i.ichg_ma < meas_i.end_of_charge_current_ma;

  always_comb begin
    logic [4:0] code;
    code = fast_charge_current_code;
    // Reserved codes would exceed the cell rating, so they clamp at the top.
    if (code > ccv_pkg::CC_MAX_CODE) begin
      code = ccv_pkg::CC_MAX_CODE;
    end
    base_ma = 11'(ccv_pkg::IFC_BASE_MA
            + ccv_pkg::IFC_STEP_MA * 11'(code));
  end

  // The floor loop sits 300 mV under the selected system floor.
  assign loop_mv = 13'(ccv_pkg::SYSMIN_MV[system_min_voltage_sel]
                 - ccv_pkg::LOOP_DROP_MV);
  assign low_vsys = meas_i.vsys_mv < loop_mv;
  assign cap_ma = (input_current_limit_sel_i == 4'h0) ? ccv_pkg::LIM_MA[0]
                : ccv_pkg::LIM_MA[input_current_limit_sel_i - 4'h1];

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;

    // Register port; the reserved current bit is dropped and reads zero.
    if (req_i.wr) begin
      unique case (req_i.addr)
        ccv_pkg::ADDR_CUR:  st_next.cur_reg = req_i.wdata[6:0];
        ccv_pkg::ADDR_VREG: st_next.vreg_reg = req_i.wdata;
        default: ;
      endcase
    end
    if (otp_load_i) begin
      st_next.vreg_reg[ccv_pkg::SYSMIN_LSB +: 2] = otp_sysmin_i;
    end
    if (req_i.rd) begin
      unique case (req_i.addr)
        ccv_pkg::ADDR_CUR:  st_next.rdata = {1'b0, st_reg.cur_reg};
        ccv_pkg::ADDR_VREG: st_next.rdata = st_reg.vreg_reg;
        default: st_next.rdata = 8'h00;
      endcase
    end

    // Current setting and its automatic reductions.
    st_next.lpm = (lim_ma <= ccv_pkg::LPM_LIM_MA)
                && (meas_i.vbat_mv > ccv_pkg::LPM_VBAT_MV);
    st_next.ifc_ma = base_ma;
    if (lim_ma == ccv_pkg::LIM_FORCE_MA) begin
      st_next.ifc_ma = ccv_pkg::FORCED_MA;
    end else if (!st_next.lpm && low_vsys && cap_ma < base_ma) begin
      st_next.ifc_ma = cap_ma;
    end
    st_next.vreg_mv = cv_mv(charge_voltage_code);

    // Charge states; the watchdog outranks the timer, which outranks progress.
    st_next.deg_cnt = 20'h00000;
    unique case (st_reg.state)
      ccv_pkg::ST_IDLE: begin
        if (charge_en_i) begin
          st_next.state = ccv_pkg::ST_CC;
        end
      end
      ccv_pkg::ST_CC: begin
        if (wdog_expired_i) begin
          st_next.state = ccv_pkg::ST_WDSUSP;
        end else if (fc_timeout_i) begin
          st_next.state = ccv_pkg::ST_TFAULT;
        end else if (meas_i.vbat_mv >= st_reg.vreg_mv) begin
          st_next.state = ccv_pkg::ST_CV;
        end
      end
      ccv_pkg::ST_CV: begin
        if (below_eoc) begin
          st_next.deg_cnt = 20'(st_reg.deg_cnt + 20'h00001);
        end
        if (wdog_expired_i) begin
          st_next.state = ccv_pkg::ST_WDSUSP;
        end else if (fc_timeout_i) begin
          st_next.state = ccv_pkg::ST_TFAULT;
        end else if (below_eoc && st_reg.deg_cnt == DEG_LAST) begin
          st_next.state = ccv_pkg::ST_EOC;
        end
      end
      ccv_pkg::ST_EOC, ccv_pkg::ST_TFAULT, ccv_pkg::ST_WDSUSP: ;
      default: st_next.state = ccv_pkg::ST_IDLE;
    endcase
    // Dropping the enable aborts any cycle, including a fault.
    if (!charge_en_i) begin
      st_next.state = ccv_pkg::ST_IDLE;
    end
    if (st_next.state != ccv_pkg::ST_CV) begin
      st_next.deg_cnt = 20'h00000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.cur_reg  <= ccv_pkg::CUR_RESET;
      st_reg.vreg_reg <= ccv_pkg::VREG_RESET;
      st_reg.state    <= ccv_pkg::ST_IDLE;
      st_reg.deg_cnt  <= 20'h00000;
      st_reg.ifc_ma   <= 11'h000;
      st_reg.vreg_mv  <= 13'h0000;
      st_reg.lpm      <= 1'b0;
      st_reg.rdata    <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign charge_current_ma_o = st_reg.ifc_ma;
  assign battery_regulation_voltage_o = st_reg.vreg_mv;
  assign charger_low_power_mode_o = st_reg.lpm;
  assign charge_state_o = st_reg.state;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reg_reset_vals: assert property (
    $past(rst_i) |-> st_reg.cur_reg == 7'h00 && st_reg.vreg_reg == 8'h2b)
    else $error("register reset values wrong");
  a_ifc_top_bound: assert property (
    $past(rst_i) == 1'b0 |-> charge_current_ma_o <= 11'h3e8)
    else $error("charge current above 1000 mA");
  a_force_fifty: assert property (
    lim_ma == 11'h064 |=> charge_current_ma_o == 11'h032)
    else $error("100 mA limit did not force 50 mA");
  a_vsys_cap: assert property (
    lim_ma != 11'h064 && !st_next.lpm && low_vsys
    |=> charge_current_ma_o <= $past(cap_ma))
    else $error("current not capped below input limit");
  a_low_power_entry: assert property (
    lim_ma <= 11'h032 && meas_i.vbat_mv > 13'haf0
    |=> charger_low_power_mode_o)
    else $error("low-power mode not entered");
  a_cv_voltage_map: assert property (
    !$past(rst_i) && charge_voltage_code == 6'h08
    ##1 charge_voltage_code == 6'h08 |-> st_reg.vreg_mv == 13'h0dac)
    else $error("flat voltage code not 3.50 V");
  a_cv_step_map: assert property (
    charge_voltage_code == 6'h27 ##1 charge_voltage_code == 6'h27
    |-> st_reg.vreg_mv == 13'h1018)
    else $error("code 39 not 4.12 V");
  a_cc_to_cv: assert property (
    st_reg.state == ccv_pkg::ST_CC && charge_en_i && !wdog_expired_i
    && !fc_timeout_i && meas_i.vbat_mv >= st_reg.vreg_mv
    |=> st_reg.state == ccv_pkg::ST_CV)
    else $error("no move to constant voltage");
  a_eoc_needs_time: assert property (
    st_reg.state == ccv_pkg::ST_CV ##1 st_reg.state == ccv_pkg::ST_EOC
    |-> $past(st_reg.deg_cnt) == DEG_LAST && $past(below_eoc))
    else $error("end of charge entered early");
  a_deg_restart: assert property (
    st_reg.state == ccv_pkg::ST_CV && !below_eoc |=> st_reg.deg_cnt == 20'h0)
    else $error("deglitch count not restarted");
  a_cv_timeout: assert property (
    st_reg.state == ccv_pkg::ST_CV && charge_en_i && fc_timeout_i
    && !wdog_expired_i |=> st_reg.state == ccv_pkg::ST_TFAULT)
    else $error("timeout did not fault");
  a_cv_watchdog: assert property (
    st_reg.state == ccv_pkg::ST_CV && charge_en_i && wdog_expired_i
    |=> st_reg.state == ccv_pkg::ST_WDSUSP)
    else $error("watchdog did not suspend");

  c_cv_reached: cover property (
    st_reg.state == ccv_pkg::ST_CC ##1 st_reg.state == ccv_pkg::ST_CV);
  c_eoc_reached: cover property (
    st_reg.state == ccv_pkg::ST_CV ##1 st_reg.state == ccv_pkg::ST_EOC);
  c_low_power: cover property ($rose(charger_low_power_mode_o));
  c_capped: cover property (
    low_vsys && !st_next.lpm ##1 charge_current_ma_o < 11'h3e8);

endmodule : ccv_charger_ctrl

// *** ccv_pkg.sv ***
// Package with the register map, encodings, limits and timing of the block.
package ccv_pkg;

  // Register offsets and reset values.
  localparam logic [7:0] ADDR_CUR   = 8'h8e;
  localparam logic [7:0] ADDR_VREG  = 8'h8f;
  localparam logic [6:0] CUR_RESET  = 7'h00;
  localparam logic [7:0] VREG_RESET = 8'h2b;

  // Field positions.
  localparam int CC_LSB     = 0;
  localparam int PRE_LSB    = 5;
  localparam int CV_LSB     = 0;
  localparam int SYSMIN_LSB = 6;

  // Fast-charge current code scale, in mA.
  localparam logic [10:0] IFC_BASE_MA = 11'h064;
  localparam logic [10:0] IFC_STEP_MA = 11'h032;
  localparam logic [4:0]  CC_MAX_CODE = 5'h12;
  localparam logic [10:0] IFC_MAX_MA  = 11'h3e8;

  // Input current limit settings, index 0 is the lowest, in mA.
  localparam logic [15:0][10:0] LIM_MA = {
    11'h5dc, 11'h1f4, 11'h190, 11'h12c, 11'h0c8, 11'h096, 11'h064, 11'h032,
    11'h02d, 11'h028, 11'h023, 11'h01e, 11'h019, 11'h014, 11'h00f, 11'h00a};
  localparam logic [10:0] LIM_FORCE_MA = 11'h064;
  localparam logic [10:0] FORCED_MA    = 11'h032;
  localparam logic [10:0] LPM_LIM_MA   = 11'h032;
  localparam logic [12:0] LPM_VBAT_MV  = 13'haf0;

  // System voltage floor selector, in mV; code 3 is reserved.
  localparam logic [3:0][12:0] SYSMIN_MV = {
    13'h10cc, 13'h10cc, 13'h0e74, 13'h0dac};
  localparam logic [12:0] LOOP_DROP_MV = 13'h12c;

  // Charge voltage code scale, in mV.
  localparam logic [12:0] CV_BASE_MV   = 13'h0dac;
  localparam logic [12:0] CV_STEP_MV   = 13'h0014;
  localparam logic [5:0]  CV_FLAT_CODE = 6'h08;
  localparam logic [5:0]  CV_CEIL_CODE = 6'h37;

  // Timing.
  localparam int CLK_FREQ_MHZ     = 50;
  localparam int DEGLITCH_TIME_US = 16000;
  localparam int DEGLITCH_CYC     = DEGLITCH_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CC     = 3'b001,
    ST_CV     = 3'b010,
    ST_EOC    = 3'b011,
    ST_TFAULT = 3'b100,
    ST_WDSUSP = 3'b101
  } ccv_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccv_req_t;

  typedef struct packed {
    logic [12:0] vbat_mv;
    logic [12:0] vsys_mv;
    logic [10:0] ichg_ma;
    logic [10:0] end_of_charge_current_ma;
  } ccv_meas_t;

  typedef struct packed {
    logic [6:0]  cur_reg;
    logic [7:0]  vreg_reg;
    ccv_state_t  state;
    logic [19:0] deg_cnt;
    logic [10:0] ifc_ma;
    logic [12:0] vreg_mv;
    logic        lpm;
    logic [7:0]  rdata;
  } ccv_regs_t;

endpackage : ccv_pkg

// *** ccv_batt_model.sv ***
// Behavioural cell and input source seen by the charge controller.
`timescale 1ns/10ps
module ccv_batt_model (
  input  wire logic                clk_i,
  input  wire ccv_pkg::ccv_state_t state_i,
  input  wire logic [10:0]         iset_i,
  input  wire logic                load_i,
  input  wire logic [12:0]         vbat0_i,
  input  wire logic [12:0]         vsys_i,
  input  wire logic                kick_i,
  output ccv_pkg::ccv_meas_t       meas_o
);
  logic [12:0] vbat_reg;
  logic [10:0] ichg_reg;

  // The cell climbs 20 mV a cycle under constant current. A real cell is
  // far slower, which would only stretch the run. The current halves each
  // cycle in constant voltage, a coarse stand-in for the exponential tail.
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      vbat_reg <= vbat0_i;
    end else if (state_i == ccv_pkg::ST_CC) begin
      vbat_reg <= vbat_reg + 13'h014;
    end
    if (kick_i || state_i == ccv_pkg::ST_CC) begin
      ichg_reg <= iset_i;
    end else if (state_i == ccv_pkg::ST_CV) begin
      ichg_reg <= ichg_reg >> 1;
    end else begin
      ichg_reg <= 11'h000;
    end
  end
  assign meas_o = '{vbat_reg, vsys_i, ichg_reg, 11'h032};
endmodule : ccv_batt_model

// *** ccv_charger_ctrl_tb.sv ***
// Self-checking testbench for the charge current and voltage control.
`timescale 1ns/10ps
module ccv_charger_ctrl_tb;
  localparam int DEG = 8;
  logic clk_i, rst_i, en, fc_to, wdog, otp_load, load, kick;
  logic [1:0] otp_sel;
  logic [3:0] input_current_limit;
  logic [12:0] vbat0, vsys, vmv;
  logic [10:0] ima;
  logic [7:0] rdata;
  logic lpm;
  ccv_pkg::ccv_req_t req;
  ccv_pkg::ccv_meas_t meas;
  ccv_pkg::ccv_state_t st;
  int num_errors = 0;
  int num_checks = 0;

  ccv_charger_ctrl #(.DEGLITCH_CYCLES(DEG)) i_ccv_charger_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .meas_i(meas),
    .input_current_limit_sel_i(input_current_limit), .charge_en_i(en), .fc_timeout_i(fc_to),
    .wdog_expired_i(wdog), .otp_load_i(otp_load), .otp_sysmin_i(otp_sel),
    .reg_rdata_o(rdata), .charge_current_ma_o(ima),
    .battery_regulation_voltage_o(vmv),
    .charger_low_power_mode_o(lpm), .charge_state_o(st));
  ccv_batt_model i_ccv_batt_model (
    .clk_i(clk_i), .state_i(st), .iset_i(ima), .load_i(load),
    .vbat0_i(vbat0), .vsys_i(vsys), .kick_i(kick), .meas_o(meas));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk_val(input string w, input logic [12:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", w, e, g);
    end
  endtask : chk_val
  task automatic chk_reg(input logic [7:0] a, e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR reg %h expected %h seen %h", a, e, g);
    end
  endtask : chk_reg
  task automatic chk_st(input ccv_pkg::ccv_state_t e);
    num_checks++;
    if (st !== e) begin
      num_errors++;
      $display("ERROR state expected %0d seen %0d", e, st);
    end
  endtask : chk_st
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    chk_reg(a, e, rdata);
    // Read data stands for one cycle only, then the port shows zero.
    tick(1);
    chk_reg(a, 8'h00, rdata);
  endtask : rd
  task automatic set_vbat(input logic [12:0] v);
    @(posedge clk_i);
    load <= 1'b1;
    vbat0 <= v;
    @(posedge clk_i);
    load <= 1'b0;
    tick(2);
  endtask : set_vbat
  task automatic wait_st(input ccv_pkg::ccv_state_t s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) tick(1);
    chk_st(s);
  endtask : wait_st

  task automatic t_regs;
    rd(8'h8e, 8'h00);
    rd(8'h8f, 8'h2b);
    wr(8'h8e, 8'hff);
    rd(8'h8e, 8'h7f);
    rd(8'h8a, 8'h00);
    @(posedge clk_i);
    otp_sel <= 2'h2;
    otp_load <= 1'b1;
    @(posedge clk_i);
    otp_load <= 1'b0;
    rd(8'h8f, 8'hab);
    $display("test regs done");
  endtask : t_regs

  task automatic t_codes;
    for (int c = 0; c < 32; c++) begin
      wr(8'h8e, 8'(c));
      tick(1);
      chk_val("current", 13'(100 + 50 * (c > 18 ? 18 : c)), 13'(ima));
    end
    for (int c = 0; c < 64; c++) begin
      wr(8'h8f, 8'(c));
      tick(1);
      chk_val("voltage", 13'(c <= 8 ? 3500 : 3340 + 20 * (c > 55 ? 55 : c)),
              vmv);
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_limits;
    int fl;
    wr(8'h8e, 8'h12);
    @(posedge clk_i);
    input_current_limit <= 4'h9;
    tick(2);
    chk_val("forced", 13'h032, 13'(ima));
    @(posedge clk_i);
    input_current_limit <= 4'hf;
    for (int s = 0; s < 3; s++) begin
      fl = (s == 0) ? 3500 : (s == 1) ? 3700 : 4300;
      wr(8'h8f, {2'(s), 6'h2b});
      @(posedge clk_i);
      vsys <= 13'(fl - 301);
      tick(2);
      chk_val("capped", 13'h1f4, 13'(ima));
      @(posedge clk_i);
      vsys <= 13'(fl - 300);
      tick(2);
      chk_val("uncapped", 13'h3e8, 13'(ima));
    end
    @(posedge clk_i);
    vsys <= 13'h1388;
    input_current_limit <= 4'h8;
    set_vbat(13'haf1);
    chk_val("lpm", 13'h001, 13'(lpm));
    set_vbat(13'haf0);
    chk_val("lpm", 13'h000, 13'(lpm));
    @(posedge clk_i);
    input_current_limit <= 4'h9;
    set_vbat(13'haf1);
    chk_val("lpm", 13'h000, 13'(lpm));
    $display("test limits done");
  endtask : t_limits

  task automatic t_charge;
    @(posedge clk_i);
    input_current_limit <= 4'hf;
    wr(8'h8f, 8'h2b);
    set_vbat(13'h1004);
    @(posedge clk_i);
    en <= 1'b1;
    wait_st(ccv_pkg::ST_CV, 40);
    chk_val("vbat at cv", 13'h001, 13'(meas.vbat_mv >= 13'h1068));
    for (int i = 0; i < 20 && meas.ichg_ma >= 11'h032; i++) tick(1);
    tick(DEG - 4);
    @(posedge clk_i);
    kick <= 1'b1;
    @(posedge clk_i);
    kick <= 1'b0;
    tick(10);
    chk_st(ccv_pkg::ST_CV);
    wait_st(ccv_pkg::ST_EOC, 20);
    $display("test charge done");
  endtask : t_charge

  task automatic t_exit(input logic wd, input ccv_pkg::ccv_state_t e);
    @(posedge clk_i);
    en <= 1'b0;
    tick(2);
    chk_st(ccv_pkg::ST_IDLE);
    set_vbat(13'h1004);
    @(posedge clk_i);
    en <= 1'b1;
    wait_st(ccv_pkg::ST_CV, 40);
    @(posedge clk_i);
    fc_to <= ~wd;
    wdog <= wd;
    @(posedge clk_i);
    fc_to <= 1'b0;
    wdog <= 1'b0;
    tick(1);
    chk_st(e);
    $display("test exit done");
  endtask : t_exit

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // The limit lies over 30 times above the whole run, which takes under 600 cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test;
  end

  initial begin
    rst_i = 1'b1;
    {en, fc_to, wdog, otp_load, kick, otp_sel} = 7'h00;
    req = '0;
    input_current_limit = 4'hf;
    vsys = 13'h1388;
    vbat0 = 13'h0ed8;
    load = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    load <= 1'b0;
    t_regs;
    t_codes;
    t_limits;
    wr(8'h8e, 8'h12);
    t_charge;
    t_exit(1'b0, ccv_pkg::ST_TFAULT);
    t_exit(1'b1, ccv_pkg::ST_WDSUSP);
    end_of_test;
  end
endmodule : ccv_charger_ctrl_tb
